// *** design/psc_regs.sv ***
// Operation
// (RULE1) bit 7 masks under-voltage warning interrupt
// (RULE2) bit 5 masks ramp-done interrupt
// (RULE3) bit 3 masks regulator over-current interrupt
// (RULE4) bit 1 masks over-temperature; even bits reserved
// (RULE5) input n mask at bit n, 0..4
// (RULE6) secondary target changes only with bit 6
// (RULE7) main target changes only with bit 5
// (RULE8) system target changes only with bit 4
// (RULE9) power-down to slot 0 or partial pointer
// (RULE10) soft-start bit slows converter start-up
// (RULE11) block wake-ups after limited watchdog restarts
// (RULE12) key lock picks key-delay controlled power-down
// (RULE13) reset pin asserted during low power optionally
// (RULE14) watchdog runs in sleep only when enabled
// (RULE15) apply programmed supply defaults at slot 0
// (RULE16) ramp step time 4,2,1,0.5 us; double
// (RULE17) reload defaults on each wake when set
// (RULE18) auto-start after reset, else wait wake
// (RULE19) debounce code selects input filter time
// (RULE20) watchdog timeout 2.048 s times 2^(N-1)
// (RULE21) interrupt only from unmasked events
// (RULE22) target change requests domain up or down
`timescale 1ns/1ps
module psc_regs
  import psc_pkg::*;
#(
  parameter int DEB1 = DEB1_CYC,
  parameter int DEB2 = DEB2_CYC,
  parameter int DEB3 = DEB3_CYC,
  parameter int DEB4 = DEB4_CYC,
  parameter int DEB5 = DEB5_CYC,
  parameter int DEB6 = DEB6_CYC,
  parameter int DEB7 = DEB7_CYC,
  parameter int WDG_BASE = WDG_BASE_CYC,
  parameter int SLOT_W = 4
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port from the two-wire interface
  input wire psc_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  // event levels from the event flag registers
  input wire logic [7:0] supply_events,
  input wire logic [4:0] input_events,
  output logic irq_out,
  // pins, asynchronous
  input wire logic sys_enable_input,
  input wire logic power_key_input_n,
  input wire logic reset_request_input_n,
  input wire logic [4:0] gpi,
  // sequencer side
  input wire psc_seq_stat_s seq_stat,
  input wire logic [SLOT_W-1:0] partial_stop_slot_pointer,
  output logic [2:0] domain_up_req,
  output logic [2:0] domain_down_req,
  output logic power_down_req,
  output logic [SLOT_W-1:0] power_down_slot,
  output logic auto_start_req,
  output logic default_supply_apply,
  output logic reload_defaults_on_wake,
  output logic wake_blocked,
  output logic power_key_lock,
  // regulator side
  output logic converter_soft_start,
  output logic ramp_step_tick,
  output logic ramp_step_tick_b3,
  // debounced inputs: gpi, power key, reset request
  output logic [6:0] filtered_inputs,
  // watchdog and reset pin
  output logic timer_running,
  output logic watchdog_timeout,
  output logic system_reset_output_n
);

  localparam int DC_W = 26;
  localparam int WDG_W = 27;

  // elaboration check: counts must fit the counters
  if (DEB7 >= (1 << DC_W) || WDG_BASE >= (1 << WDG_W) || DEB1 < 1 ||
      SLOT_W < 1)
  begin : g_bad_params
    $error("psc_regs: counts out of range");
  end

  // whole state of the bank
  typedef struct packed {
    logic [7:0] smask;
    logic [7:0] imask;
    logic [7:0] pdc;
    logic [7:0] pbc;
    logic [7:0] sdc;
    logic [7:0] wsc;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [6:0] filt;
    logic [6:0][DC_W-1:0] dcnt;
    logic sys_enable_input_d;
    logic low_power_d;
    logic [2:0] up;
    logic [2:0] down;
    logic pd_req;
    logic [SLOT_W-1:0] pd_slot;
    logic auto_start;
    logic def_apply;
    logic reload;
    logic [1:0] restarts;
    logic blocked;
    logic [8:0] ramp_cnt;
    logic ramp_tick;
    logic ramp_tick_b3;
    logic b3_phase;
    logic [WDG_W-1:0] wdg_base;
    logic [6:0] wdg_ticks;
    logic wdg_run;
    logic wdg_to;
    logic rst_n;
  } psc_state_s;

  psc_state_s st;
  psc_state_s next_st;

  // debounce length per code
  function automatic logic [DC_W-1:0] deb_len(input logic [2:0] code);
    unique case (code)
      3'h1: deb_len = DC_W'(DEB1);
      3'h2: deb_len = DC_W'(DEB2);
      3'h3: deb_len = DC_W'(DEB3);
      3'h4: deb_len = DC_W'(DEB4);
      3'h5: deb_len = DC_W'(DEB5);
      3'h6: deb_len = DC_W'(DEB6);
      3'h7: deb_len = DC_W'(DEB7);
      3'h0: deb_len = '0;
    endcase
  endfunction : deb_len

  // next-state logic
  always_comb
  begin
    logic [7:0] wd;
    logic [2:0] wmask;
    logic [2:0] new_tgt;
    logic [6:0] raw;
    logic wake_edge;
    logic sleep_edge;
    logic [8:0] ramp_end;
    logic [6:0] wdg_limit;
    wd = reg_req.wdata;
    wmask = '0;
    new_tgt = '0;
    raw = '0;
    wake_edge = 1'b0;
    sleep_edge = 1'b0;
    ramp_end = '0;
    wdg_limit = '0;
    next_st = st;
    // pin synchronisers, first stage read only by second
    next_st.sync1 = {reset_request_input_n, power_key_input_n,
      sys_enable_input, gpi};
    next_st.sync2 = st.sync1;
    // single-cycle outputs default low
    next_st.up = '0;
    next_st.down = '0;
    next_st.pd_req = 1'b0;
    next_st.auto_start = 1'b0;
    next_st.def_apply = 1'b0;
    next_st.reload = 1'b0;
    next_st.ramp_tick = 1'b0;
    next_st.ramp_tick_b3 = 1'b0;
    next_st.wdg_to = 1'b0;
    // register writes
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        SUPPLY_EVENT_MASK_OFS:
          next_st.smask = wd & SUPPLY_MASK_USED; // RULE1 RULE2 RULE3 RULE4
        INPUT_EVENT_MASK_OFS:
          next_st.imask = wd; // RULE5
        POWER_DOMAIN_CONTROL_OFS:
        begin
          // targets move only where the write mask bit is set
          wmask = wd[DOMAIN_WMASK_LSB +: 3];
          new_tgt = (wd[2:0] & wmask) |
            (st.pdc[2:0] & ~wmask); // RULE6 RULE7 RULE8
          next_st.pdc = {wd[7:3], new_tgt};
          next_st.up = new_tgt & ~st.pdc[2:0]; // RULE22
          next_st.down = st.pdc[2:0] & ~new_tgt; // RULE22
        end
        LOW_POWER_STATE_BEHAVIOUR_CONTROL_OFS:
          next_st.pbc = wd;
        STARTUP_DEBOUNCE_CONTROL_OFS:
          next_st.sdc = wd;
        WATCHDOG_SCALE_CONTROL_OFS:
          next_st.wsc = wd;
        default:
          next_st.pbc = st.pbc; // unmapped writes are ignored
      endcase
    end
    // register reads, unmapped reads answer zero
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        SUPPLY_EVENT_MASK_OFS: next_st.rdata = st.smask;
        INPUT_EVENT_MASK_OFS: next_st.rdata = st.imask;
        POWER_DOMAIN_CONTROL_OFS: next_st.rdata = st.pdc;
        LOW_POWER_STATE_BEHAVIOUR_CONTROL_OFS: next_st.rdata = st.pbc;
        STARTUP_DEBOUNCE_CONTROL_OFS: next_st.rdata = st.sdc;
        WATCHDOG_SCALE_CONTROL_OFS: next_st.rdata = st.wsc;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // interrupt from unmasked events only
    next_st.irq = |(supply_events & SUPPLY_MASK_USED & ~st.smask) |
      |(input_events & ~st.imask[4:0]); // RULE21
    // input debounce, one filter per gpi, power key and reset request input; system enable is not filtered
    raw = {st.sync2[7], st.sync2[6], st.sync2[4:0]};
    for (int i = 0; i < 7; i++)
    begin
      if (raw[i] == st.filt[i])
        next_st.dcnt[i] = '0;
      else if (st.dcnt[i] >= deb_len(st.sdc[2:0]))
      begin
        next_st.filt[i] = raw[i]; // RULE19
        next_st.dcnt[i] = '0;
      end
      else
        next_st.dcnt[i] = st.dcnt[i] + 1'b1;
    end
    // power-down triggers, system enable falling after sync
    next_st.sys_enable_input_d = st.sync2[5];
    if (next_st.down[SYSTEM_TARGET_BIT] || (st.sys_enable_input_d && !st.sync2[5]) ||
        seq_stat.long_key_press)
    begin
      next_st.pd_req = 1'b1; // RULE9
      next_st.pd_slot = st.pdc[PARTIAL_DOWN_BIT] ?
        partial_stop_slot_pointer : '0; // RULE9
    end
    // low power transitions
    next_st.low_power_d = seq_stat.in_low_power;
    wake_edge = st.low_power_d & ~seq_stat.in_low_power;
    sleep_edge = ~st.low_power_d & seq_stat.in_low_power;
    next_st.reload = wake_edge & st.sdc[RELOAD_DEFAULTS_ON_WAKE_BIT]; // RULE17
    // reset pin follows low power only in transition mode
    if (!st.pbc[RESET_PIN_MODE_BIT])
      next_st.rst_n = 1'b1; // RULE13
    else if (sleep_edge)
      next_st.rst_n = 1'b0; // RULE13
    else if (wake_edge)
      next_st.rst_n = 1'b1; // RULE13
    // sequencer start and slot 0 actions
    next_st.auto_start = seq_stat.left_reset & st.sdc[AUTO_START_BIT]; // RULE18
    next_st.def_apply = seq_stat.enter_slot0 &
      st.sdc[DEFAULT_SUPPLY_APPLY_BIT]; // RULE15
    // ramp step ticks, third buck every second step
    ramp_end = 9'(RAMP_STEP_MAX_CYC >> st.sdc[RAMP_STEP_LSB +: 2]);
    if (st.ramp_cnt + 9'h001 >= ramp_end)
    begin
      next_st.ramp_cnt = '0;
      next_st.ramp_tick = 1'b1; // RULE16
      next_st.ramp_tick_b3 = st.b3_phase; // RULE16
      next_st.b3_phase = ~st.b3_phase;
    end
    else
      next_st.ramp_cnt = st.ramp_cnt + 1'b1;
    // watchdog runs when enabled, in sleep only if allowed
    next_st.wdg_run = (st.wsc[2:0] != 3'h0) && (!seq_stat.in_low_power ||
      st.pbc[TIMER_RUN_IN_SLEEP_BIT]); // RULE14 RULE20
    wdg_limit = 7'(7'h01 << (st.wsc[2:0] - 3'h1)); // RULE20
    if (!st.wdg_run || seq_stat.watchdog_kick)
    begin
      next_st.wdg_base = '0;
      next_st.wdg_ticks = '0;
    end
    else if (st.wdg_base + 1'b1 >= WDG_W'(WDG_BASE))
    begin
      next_st.wdg_base = '0;
      if (st.wdg_ticks + 7'h01 >= wdg_limit)
      begin
        next_st.wdg_ticks = '0;
        next_st.wdg_to = 1'b1; // RULE20
      end
      else
        next_st.wdg_ticks = st.wdg_ticks + 7'h01;
    end
    else
      next_st.wdg_base = st.wdg_base + 1'b1;
    // restart trials counted on watchdog timeouts, saturating at 3
    if (st.wdg_to && st.restarts != 2'h3)
      next_st.restarts = st.restarts + 2'h1; // RULE11
    next_st.blocked = st.pbc[RESTART_LIMIT_EN_BIT] &&
      (st.restarts >= st.pbc[RESTART_LIMIT_LSB +: 2]); // RULE11
  end

  // state register
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.smask <= SUPPLY_EVENT_MASK_RST;
      st.imask <= INPUT_EVENT_MASK_RST;
      st.pdc <= POWER_DOMAIN_CONTROL_RST;
      st.pbc <= LOW_POWER_STATE_BEHAVIOUR_CONTROL_RST;
      st.sdc <= STARTUP_DEBOUNCE_CONTROL_RST;
      st.wsc <= WATCHDOG_SCALE_CONTROL_RST;
      st.sync1 <= PIN_SYNC_RST;
      st.sync2 <= PIN_SYNC_RST;
      st.filt <= FILTERED_RST;
      st.rst_n <= 1'b1;
    end
    else
      st <= next_st;
  end

  // outputs straight from the state flip-flops
  assign reg_rdata = st.rdata;
  assign irq_out = st.irq;
  assign domain_up_req = st.up;
  assign domain_down_req = st.down;
  assign power_down_req = st.pd_req;
  assign power_down_slot = st.pd_slot;
  assign auto_start_req = st.auto_start;
  assign default_supply_apply = st.def_apply;
  assign reload_defaults_on_wake = st.reload;
  assign wake_blocked = st.blocked;
  assign power_key_lock = st.pbc[POWER_KEY_LOCK_BIT]; // RULE12
  assign converter_soft_start = st.pbc[CONVERTER_SOFT_START_BIT]; // RULE10
  assign ramp_step_tick = st.ramp_tick;
  assign ramp_step_tick_b3 = st.ramp_tick_b3;
  assign filtered_inputs = st.filt;
  assign timer_running = st.wdg_run;
  assign watchdog_timeout = st.wdg_to;
  assign system_reset_output_n = st.rst_n;

endmodule : psc_regs

// *** design/psc_pkg.sv ***
package psc_pkg;
  // register offsets on the 9-bit register address space
  localparam logic [8:0] SUPPLY_EVENT_MASK_OFS = 9'h00B;
  localparam logic [8:0] INPUT_EVENT_MASK_OFS = 9'h00C;
  localparam logic [8:0] POWER_DOMAIN_CONTROL_OFS = 9'h00E;
  localparam logic [8:0] LOW_POWER_STATE_BEHAVIOUR_CONTROL_OFS = 9'h00F;
  localparam logic [8:0] STARTUP_DEBOUNCE_CONTROL_OFS = 9'h010;
  localparam logic [8:0] WATCHDOG_SCALE_CONTROL_OFS = 9'h011;
  // reset values
  localparam logic [7:0] SUPPLY_EVENT_MASK_RST = 8'h00;
  localparam logic [7:0] INPUT_EVENT_MASK_RST = 8'h00;
  localparam logic [7:0] POWER_DOMAIN_CONTROL_RST = 8'h00;
  localparam logic [7:0] LOW_POWER_STATE_BEHAVIOUR_CONTROL_RST = 8'h00;
  localparam logic [7:0] STARTUP_DEBOUNCE_CONTROL_RST = 8'h00;
  localparam logic [7:0] WATCHDOG_SCALE_CONTROL_RST = 8'h00;
  // pin synchroniser and filter idle levels: key and reset request high, system enable also high in the synchroniser
  localparam logic [7:0] PIN_SYNC_RST = 8'hE0;
  localparam logic [6:0] FILTERED_RST = 7'h60;
  // supply event mask fields, implemented bits only
  localparam logic [7:0] SUPPLY_MASK_USED = 8'hAA;
  // power domain control fields
  localparam int DOMAIN_WMASK_LSB = 4;
  localparam int PARTIAL_DOWN_BIT = 3;
  localparam int SYSTEM_TARGET_BIT = 0;
  // low_power_state behaviour fields
  localparam int CONVERTER_SOFT_START_BIT = 7;
  localparam int RESTART_LIMIT_LSB = 5;
  localparam int POWER_KEY_LOCK_BIT = 4;
  localparam int RESET_PIN_MODE_BIT = 3;
  localparam int RESTART_LIMIT_EN_BIT = 2;
  localparam int TIMER_RUN_IN_SLEEP_BIT = 1;
  // startup and debounce fields
  localparam int DEFAULT_SUPPLY_APPLY_BIT = 7;
  localparam int RAMP_STEP_LSB = 5;
  localparam int RELOAD_DEFAULTS_ON_WAKE_BIT = 4;
  localparam int AUTO_START_BIT = 3;
  // clock and timing
  localparam real MCLK_MHZ = 40.0;
  localparam real RAMP_STEP_MAX_US = 4.0;
  localparam int RAMP_STEP_MAX_CYC = int'(RAMP_STEP_MAX_US * MCLK_MHZ);
  localparam real DEB_MS [1:7] = '{0.1, 1.0, 10.24, 51.2, 256.0, 512.0,
    1024.0};
  localparam int DEB1_CYC = int'(DEB_MS[1] * MCLK_MHZ * 1000.0);
  localparam int DEB2_CYC = int'(DEB_MS[2] * MCLK_MHZ * 1000.0);
  localparam int DEB3_CYC = int'(DEB_MS[3] * MCLK_MHZ * 1000.0);
  localparam int DEB4_CYC = int'(DEB_MS[4] * MCLK_MHZ * 1000.0);
  localparam int DEB5_CYC = int'(DEB_MS[5] * MCLK_MHZ * 1000.0);
  localparam int DEB6_CYC = int'(DEB_MS[6] * MCLK_MHZ * 1000.0);
  localparam int DEB7_CYC = int'(DEB_MS[7] * MCLK_MHZ * 1000.0);
  localparam real WDG_BASE_S = 2.048;
  localparam int WDG_BASE_CYC = int'(WDG_BASE_S * MCLK_MHZ * 1.0e6);
  // register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } psc_reg_req_s;
  // sequencer handshakes towards this bank
  typedef struct packed {
    logic in_low_power;
    logic enter_slot0;
    logic left_reset;
    logic long_key_press;
    logic watchdog_kick;
  } psc_seq_stat_s;
endpackage : psc_pkg

// *** design/psc_unused.sv ***
`timescale 1ns/1ps

// *** bench/psc_host_model.sv ***
`timescale 1ns/1ps
module psc_host_model
  import psc_pkg::*;
(
  // clock
  input wire logic mclk,
  // register port
  output psc_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata
);
  initial reg_req = '0;
  // one write; the caller sets the mask bit of every target it means to move
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  // one read; data is valid the cycle after the strobe edge
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
    @(posedge mclk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
    d = reg_rdata;
  endtask : rd
endmodule : psc_host_model

// *** bench/psc_regs_props.sv ***
`timescale 1ns/1ps
module psc_regs_props
  import psc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // inputs
  input wire psc_reg_req_s reg_req,
  input wire logic [7:0] supply_events,
  input wire logic [4:0] input_events,
  input wire psc_seq_stat_s seq_stat,
  // outputs
  input wire logic [7:0] reg_rdata,
  input wire logic irq_out,
  input wire logic [2:0] domain_up_req,
  input wire logic [2:0] domain_down_req,
  input wire logic power_down_req,
  input wire logic timer_running,
  input wire logic watchdog_timeout,
  input wire logic system_reset_output_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // unmasked domain writes must not move a domain
  property p_dom_sec;
    reg_req.wr && reg_req.addr == POWER_DOMAIN_CONTROL_OFS && !reg_req.wdata[6]
    |=> domain_up_req[2] == 1'b0 && domain_down_req[2] == 1'b0;
  endproperty
  a_dom_sec: assert property (p_dom_sec)
    else $error("secondary domain moved without mask");
  property p_dom_main;
    reg_req.wr && reg_req.addr == POWER_DOMAIN_CONTROL_OFS && !reg_req.wdata[5]
    |=> domain_up_req[1] == 1'b0 && domain_down_req[1] == 1'b0;
  endproperty
  a_dom_main: assert property (p_dom_main)
    else $error("main domain moved without mask");
  property p_dom_sys;
    reg_req.wr && reg_req.addr == POWER_DOMAIN_CONTROL_OFS && !reg_req.wdata[4]
    |=> domain_up_req[0] == 1'b0 && domain_down_req[0] == 1'b0;
  endproperty
  a_dom_sys: assert property (p_dom_sys)
    else $error("system domain moved without mask");
  // reserved supply mask bits read as zero
  property p_rsv;
    reg_req.rd && reg_req.addr == SUPPLY_EVENT_MASK_OFS
    |=> (reg_rdata & ~SUPPLY_MASK_USED) == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved supply mask bit read back set");
  // no events, no interrupt
  property p_irq;
    supply_events == 8'h00 && input_events == 5'h00 |=> !irq_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without event");
  // a long key press always asks for power-down
  property p_pd;
    seq_stat.long_key_press |=> power_down_req;
  endproperty
  a_pd: assert property (p_pd)
    else $error("long key press without power-down request");
  // timeout only from a running timer
  property p_wdg;
    watchdog_timeout |-> $past(timer_running);
  endproperty
  a_wdg: assert property (p_wdg)
    else $error("timeout while timer stopped");
  // reset pin released while out of low power
  property p_rstn;
    !seq_stat.in_low_power && !$past(seq_stat.in_low_power)
    |-> system_reset_output_n;
  endproperty
  a_rstn: assert property (p_rstn)
    else $error("reset pin low outside low power");
endmodule : psc_regs_props
bind psc_regs psc_regs_props u_props (.mclk(mclk), .nrst(nrst),
  .reg_req(reg_req), .supply_events(supply_events),
  .input_events(input_events), .seq_stat(seq_stat), .reg_rdata(reg_rdata),
  .irq_out(irq_out), .domain_up_req(domain_up_req),
  .domain_down_req(domain_down_req), .power_down_req(power_down_req),
  .timer_running(timer_running), .watchdog_timeout(watchdog_timeout),
  .system_reset_output_n(system_reset_output_n));

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb
  import psc_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] supply_events = 8'h00;
  logic [4:0] input_events = 5'h00;
  logic sys_enable_input = 1'b1;
  logic power_key_input_n = 1'b1;
  logic reset_request_input_n = 1'b1;
  logic [3:0] slot_ptr = 4'hA;
  logic [4:0] gpi = 5'h00;
  psc_seq_stat_s seq_stat = '0;
  psc_reg_req_s reg_req;
  logic [7:0] reg_rdata, rd_v;
  logic [2:0] domain_up_req, domain_down_req, pulses;
  logic [3:0] power_down_slot;
  logic [6:0] filtered_inputs;
  logic irq_out, power_down_req, auto_start_req, default_supply_apply;
  logic reload_defaults_on_wake, wake_blocked, power_key_lock;
  logic converter_soft_start, ramp_step_tick, ramp_step_tick_b3;
  logic timer_running, watchdog_timeout, system_reset_output_n;
  int n_fail = 0;
  int checked = 0;
  int n;
  // half period of 40 MHz
  always #12.5 mclk = ~mclk;
  assign pulses = {watchdog_timeout, ramp_step_tick_b3, ramp_step_tick};
  psc_regs #(.DEB1(4), .DEB7(28), .WDG_BASE(50)) DUT (
    .mclk(mclk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .supply_events(supply_events), .input_events(input_events),
    .irq_out(irq_out), .sys_enable_input(sys_enable_input),
    .power_key_input_n(power_key_input_n),
    .reset_request_input_n(reset_request_input_n),
    .gpi(gpi), .seq_stat(seq_stat), .partial_stop_slot_pointer(slot_ptr),
    .domain_up_req(domain_up_req), .domain_down_req(domain_down_req),
    .power_down_req(power_down_req), .power_down_slot(power_down_slot),
    .auto_start_req(auto_start_req),
    .default_supply_apply(default_supply_apply),
    .reload_defaults_on_wake(reload_defaults_on_wake),
    .wake_blocked(wake_blocked), .power_key_lock(power_key_lock),
    .converter_soft_start(converter_soft_start),
    .ramp_step_tick(ramp_step_tick), .ramp_step_tick_b3(ramp_step_tick_b3),
    .filtered_inputs(filtered_inputs), .timer_running(timer_running),
    .watchdog_timeout(watchdog_timeout),
    .system_reset_output_n(system_reset_output_n));
  psc_host_model host (.mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata));
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic final_report;
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic rdc(input logic [8:0] a, input logic [7:0] e, input string w);
    host.rd(a, rd_v);
    chk(w, e, rd_v);
  endtask : rdc
  // cycles between two pulses of the selected output
  task automatic gap(input int s);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        cyc(1);
        n++;
      end while (pulses[s] !== 1'b1 && n < 400);
    end
  endtask : gap
  // wait a few cycles for a power-down request and its slot
  task automatic pd_wait(input logic [3:0] slot);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 6 && !seen; i++)
    begin
      seen = power_down_req;
      if (!seen)
        cyc(1);
    end
    chk("pd_req", 8'h01, {7'h0, seen});
    chk("pd_slot", {4'h0, slot}, {4'h0, power_down_slot});
  endtask : pd_wait
  task automatic t_reset;
    chk("filt_rst", 8'h60, {1'b0, filtered_inputs});
    for (int a = 9'h00B; a < 9'h012; a++)
      rdc(9'(a), 8'h00, "rst_val");
  endtask : t_reset
  // masked event gives no interrupt, unmasked one does
  task automatic irq_case(input logic [8:0] a, input logic [7:0] m);
    host.wr(a, 8'hFF);
    cyc(2);
    chk("irq_masked", 8'h00, {7'h0, irq_out});
    host.wr(a, ~m);
    cyc(2);
    chk("irq_open", 8'h01, {7'h0, irq_out});
  endtask : irq_case
  task automatic t_mask;
    host.wr(SUPPLY_EVENT_MASK_OFS, 8'hFF);
    rdc(SUPPLY_EVENT_MASK_OFS, 8'hAA, "smask");
    host.wr(INPUT_EVENT_MASK_OFS, 8'hFF);
    rdc(INPUT_EVENT_MASK_OFS, 8'hFF, "imask");
    for (int i = 1; i < 8; i += 2)
    begin
      supply_events = 8'h01 << i;
      irq_case(SUPPLY_EVENT_MASK_OFS, 8'h01 << i);
    end
    supply_events = 8'h00;
    for (int i = 0; i < 5; i++)
    begin
      input_events = 5'h01 << i;
      irq_case(INPUT_EVENT_MASK_OFS, 8'h01 << i);
    end
    input_events = 5'h00;
  endtask : t_mask
  task automatic t_dom;
    host.wr(POWER_DOMAIN_CONTROL_OFS, 8'h77);
    chk("up_all", 8'h07, {5'h0, domain_up_req});
    host.wr(POWER_DOMAIN_CONTROL_OFS, 8'h80);
    chk("dn_none", 8'h00, {5'h0, domain_down_req});
    rdc(POWER_DOMAIN_CONTROL_OFS, 8'h87, "pdc_kept");
    host.wr(POWER_DOMAIN_CONTROL_OFS, 8'h50);
    chk("dn_two", 8'h05, {5'h0, domain_down_req});
    pd_wait(4'h0);
    rdc(POWER_DOMAIN_CONTROL_OFS, 8'h52, "pdc_part");
    host.wr(POWER_DOMAIN_CONTROL_OFS, 8'h19);
    host.wr(POWER_DOMAIN_CONTROL_OFS, 8'h18);
    pd_wait(4'hA);
    host.wr(POWER_DOMAIN_CONTROL_OFS, 8'h11);
    sys_enable_input = 1'b0;
    pd_wait(4'h0);
    sys_enable_input = 1'b1;
    seq_stat.long_key_press = 1'b1;
    cyc(1);
    seq_stat.long_key_press = 1'b0;
    pd_wait(4'h0);
  endtask : t_dom
  task automatic t_ctrl;
    host.wr(LOW_POWER_STATE_BEHAVIOUR_CONTROL_OFS, 8'h90);
    chk("soft", 8'h01, {7'h0, converter_soft_start});
    chk("lock", 8'h01, {7'h0, power_key_lock});
    for (int m = 0; m < 2; m++)
    begin
      host.wr(LOW_POWER_STATE_BEHAVIOUR_CONTROL_OFS, m ? 8'h08 : 8'h00);
      seq_stat.in_low_power = 1'b1;
      cyc(2);
      chk("rst_pin_lp", {7'h0, !m}, {7'h0, system_reset_output_n});
      seq_stat.in_low_power = 1'b0;
      cyc(2);
      chk("rst_pin_up", 8'h01, {7'h0, system_reset_output_n});
    end
  endtask : t_ctrl
  task automatic t_seq(input logic e);
    host.wr(STARTUP_DEBOUNCE_CONTROL_OFS, e ? 8'h98 : 8'h00);
    seq_stat.left_reset = 1'b1;
    cyc(1);
    seq_stat.left_reset = 1'b0;
    chk("auto", {7'h0, e}, {7'h0, auto_start_req});
    seq_stat.enter_slot0 = 1'b1;
    cyc(1);
    seq_stat.enter_slot0 = 1'b0;
    chk("defaults", {7'h0, e}, {7'h0, default_supply_apply});
    seq_stat.in_low_power = 1'b1;
    cyc(2);
    seq_stat.in_low_power = 1'b0;
    cyc(1);
    chk("reload", {7'h0, e}, {7'h0, reload_defaults_on_wake});
  endtask : t_seq
  task automatic t_ramp;
    for (int c = 0; c < 4; c++)
    begin
      host.wr(STARTUP_DEBOUNCE_CONTROL_OFS, 8'(c << 5));
      gap(0);
      chk("ramp", 8'(160 >> c), 8'(n));
    end
    gap(1);
    chk("ramp_b3", 8'd40, 8'(n));
  endtask : t_ramp
  task automatic t_deb;
    host.wr(STARTUP_DEBOUNCE_CONTROL_OFS, 8'h01);
    gpi = 5'h01;
    cyc(2);
    gpi = 5'h00;
    cyc(12);
    chk("deb_glitch", 8'h60, {1'b0, filtered_inputs});
    gpi = 5'h1F;
    power_key_input_n = 1'b0;
    reset_request_input_n = 1'b0;
    cyc(12);
    chk("deb_short", 8'h1F, {1'b0, filtered_inputs});
    host.wr(STARTUP_DEBOUNCE_CONTROL_OFS, 8'h07);
    gpi = 5'h00;
    cyc(12);
    chk("deb_wait", 8'h1F, {1'b0, filtered_inputs});
    cyc(30);
    chk("deb_long", 8'h00, {1'b0, filtered_inputs});
    power_key_input_n = 1'b1;
    reset_request_input_n = 1'b1;
  endtask : t_deb
  task automatic t_wdg;
    // no restarts yet, so a limit of one must not block
    host.wr(LOW_POWER_STATE_BEHAVIOUR_CONTROL_OFS, 8'h24);
    cyc(1);
    chk("not_blocked", 8'h00, {7'h0, wake_blocked});
    host.wr(WATCHDOG_SCALE_CONTROL_OFS, 8'h02);
    gap(2);
    chk("wdg_period", 8'd100, 8'(n));
    // a kick part-way restarts the whole timeout
    cyc(30);
    seq_stat.watchdog_kick = 1'b1;
    cyc(1);
    seq_stat.watchdog_kick = 1'b0;
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end while (watchdog_timeout !== 1'b1 && n < 400);
    chk("wdg_kick", 8'd100, 8'(n));
    seq_stat.in_low_power = 1'b1;
    cyc(2);
    chk("wdg_sleep_off", 8'h00, {7'h0, timer_running});
    host.wr(LOW_POWER_STATE_BEHAVIOUR_CONTROL_OFS, 8'h02);
    cyc(1);
    chk("wdg_sleep_on", 8'h01, {7'h0, timer_running});
    seq_stat.in_low_power = 1'b0;
    host.wr(WATCHDOG_SCALE_CONTROL_OFS, 8'h00);
    host.wr(LOW_POWER_STATE_BEHAVIOUR_CONTROL_OFS, 8'h44);
    cyc(1);
    chk("blocked", 8'h01, {7'h0, wake_blocked});
    host.wr(LOW_POWER_STATE_BEHAVIOUR_CONTROL_OFS, 8'h40);
    cyc(1);
    chk("unblocked", 8'h00, {7'h0, wake_blocked});
  endtask : t_wdg
  // hang guard
  initial
  begin
    #500000;
    n_fail++;
    final_report();
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_mask();
    t_dom();
    t_ctrl();
    t_seq(1'b1);
    t_seq(1'b0);
    t_ramp();
    t_deb();
    t_wdg();
    final_report();
  end
endmodule : tb
